// ---- rtl/lrs_bank_timer.v ----
// one bank's refresh busy timer
`timescale 1ns/100ps
module lrs_bank_timer #(
  parameter CNT_W = 8
) (
  input  wire             clock,
  input  wire             srst,
  input  wire             start,
  input  wire [CNT_W-1:0] load,
  output reg              busy
);
  reg [CNT_W-1:0] cnt_q;

  always @(posedge clock) begin
    if (srst) begin
      cnt_q <= {CNT_W{1'b0}};
      busy  <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      busy  <= 1'b1;
    end else if (cnt_q > {{(CNT_W-1){1'b0}}, 1'b1}) begin
      cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      // count ends: bank returns to idle
      cnt_q <= {CNT_W{1'b0}};
      busy  <= 1'b0;
    end
  end
endmodule // lrs_bank_timer

// ---- rtl/lrs_defs.vh ----
// constants for the refresh scheduling block
// Summary of operation
// - refresh is CS high, CA3 high, others low
// - CA5 low per-bank, CA5 high all-bank
// - per-bank bank address on second edge CA2..CA0
// - per-bank refreshes accepted in any bank order
// - set counting starts after last synchronization
// - reset and self refresh exit zero count
// - all-bank refresh also zeroes bank count
// - all-bank or self refresh allowed anytime
// - all-bank clears count, refreshes all banks
// - refresh after all-bank uses incremented row
// - target bank busy, other banks stay accessible
// - refreshed bank left idle on completion
// - all-bank leaves banks idle, then tRFCab
`ifndef LRS_DEFS_VH
`define LRS_DEFS_VH
`define LRS_CA_W        6
`define LRS_BANK_W      3
`define LRS_NBANKS      8
`define LRS_CA5_ALLBANK 5
`define LRS_REF_CODE    5'h08
`define LRS_CLK_NS      10
`define LRS_TRFCAB_NS   280
`define LRS_TRFCPB_NS   140
`define LRS_TPBR2PBR_NS 90
`define LRS_TRFCAB_CYC  ((`LRS_TRFCAB_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS)
`define LRS_TRFCPB_CYC  ((`LRS_TRFCPB_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS)
`define LRS_TPBR2PBR_CYC ((`LRS_TPBR2PBR_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS)
`endif

// ---- rtl/lrs_refresh_sched.v ----
// device-side refresh command decode, bank count and row counter
`timescale 1ns/100ps
`include "lrs_defs.vh"
module lrs_refresh_sched #(
  parameter ROW_W    = 16,
  parameter CNT_W    = 8,
  parameter TRFCAB   = `LRS_TRFCAB_CYC,
  parameter TRFCPB   = `LRS_TRFCPB_CYC
) (
  input  wire                   clock,
  input  wire                   srst,
  input  wire                   cs,
  input  wire [`LRS_CA_W-1:0]   ca,
  input  wire                   sr_exit,
  output reg                    ref_ab_q,
  output reg                    ref_pb_q,
  output reg  [`LRS_BANK_W-1:0] ref_bank_q,
  output reg  [ROW_W-1:0]       ref_row_q,
  output reg  [`LRS_BANK_W-1:0] bank_count_q,
  output reg  [ROW_W-1:0]       row_count_q,
  output reg  [`LRS_NBANKS-1:0] bank_busy_q
);
  localparam ST_IDLE = 1'b0;
  localparam ST_PB2  = 1'b1;

  reg                    state_q;
  reg                    state_d;
  wire [`LRS_NBANKS-1:0] busy;
  reg  [`LRS_NBANKS-1:0] start;
  reg                    first_edge_ref;
  reg                    first_edge_all;
  reg                    take_ab;
  reg                    take_pb;
  reg                    set_wrap;
  // next values of the registered outputs
  reg                    ref_ab_d;
  reg                    ref_pb_d;
  reg  [`LRS_BANK_W-1:0] ref_bank_d;
  reg  [ROW_W-1:0]       ref_row_d;
  reg  [`LRS_BANK_W-1:0] bank_count_d;
  reg  [ROW_W-1:0]       row_count_d;
  reg  [`LRS_NBANKS-1:0] bank_busy_d;

  function [`LRS_NBANKS-1:0] bank_onehot;
    input [`LRS_BANK_W-1:0] b;
    begin
      bank_onehot = {{(`LRS_NBANKS-1){1'b0}}, 1'b1} << b;
    end
  endfunction

  // shared counter steps; both wrap silently at their width
  function [ROW_W-1:0] row_inc;
    input [ROW_W-1:0] v;
    begin
      row_inc = v + {{(ROW_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function [`LRS_BANK_W-1:0] bank_inc;
    input [`LRS_BANK_W-1:0] v;
    begin
      bank_inc = v + {{(`LRS_BANK_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function is_ref_cmd;
    input                 sel;
    input [`LRS_CA_W-1:0] bus;
    begin
      is_ref_cmd = sel && (bus[4:0] == `LRS_REF_CODE);
    end
  endfunction

  // per-bank refresh holds only its bank, for the shorter window
  function [CNT_W-1:0] timer_load;
    input per_bank;
    begin
      timer_load = per_bank ? TRFCPB[CNT_W-1:0] : TRFCAB[CNT_W-1:0];
    end
  endfunction

  always @* begin
    first_edge_ref = is_ref_cmd(cs, ca);
    first_edge_all = ca[`LRS_CA5_ALLBANK];
    state_d        = state_q;
    start          = {`LRS_NBANKS{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (first_edge_ref && first_edge_all) begin
          start = {`LRS_NBANKS{1'b1}};
        end else if (first_edge_ref) begin
          state_d = ST_PB2;
        end
      end
      ST_PB2: begin
        start   = bank_onehot(ca[`LRS_BANK_W-1:0]);
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < `LRS_NBANKS; g = g + 1) begin : g_bank
      lrs_bank_timer #(.CNT_W(CNT_W)) u_timer (
        .clock (clock),
        .srst  (srst),
        .start (start[g]),
        // all-bank refresh holds every bank for the longer window
        .load  (timer_load(take_pb)),
        .busy  (busy[g])
      );
    end
  endgenerate

  // command decode shared by the output next-value logic and the timers
  always @* begin
    take_ab  = (state_q == ST_IDLE) && first_edge_ref && first_edge_all;
    take_pb  = (state_q == ST_PB2);
    set_wrap = (bank_count_q == {`LRS_BANK_W{1'b1}});
  end

  always @* begin
    ref_ab_d     = 1'b0;
    ref_pb_d     = 1'b0;
    ref_bank_d   = ref_bank_q;
    ref_row_d    = ref_row_q;
    bank_count_d = bank_count_q;
    row_count_d  = row_count_q;
    bank_busy_d  = busy | start;
    if (sr_exit) begin
      // self refresh may start mid-set; exit resyncs the count
      bank_count_d = {`LRS_BANK_W{1'b0}};
    end else if (take_ab) begin
      ref_ab_d     = 1'b1;
      ref_row_d    = row_count_q;
      bank_count_d = {`LRS_BANK_W{1'b0}};
      row_count_d  = row_inc(row_count_q);
    end else if (take_pb) begin
      // any bank order accepted; count ignores the address
      ref_pb_d     = 1'b1;
      ref_bank_d   = ca[`LRS_BANK_W-1:0];
      ref_row_d    = row_count_q;
      bank_count_d = bank_inc(bank_count_q);
      if (set_wrap) begin
        row_count_d = row_inc(row_count_q);
      end
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // command pulses last one cycle each
  always @(posedge clock) begin
    if (srst) begin
      ref_ab_q <= 1'b0;
    end else begin
      ref_ab_q <= ref_ab_d;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      ref_pb_q <= 1'b0;
    end else begin
      ref_pb_q <= ref_pb_d;
    end
  end

  // bank and row of the last refresh hold until the next one
  always @(posedge clock) begin
    if (srst) begin
      ref_bank_q <= {`LRS_BANK_W{1'b0}};
    end else begin
      ref_bank_q <= ref_bank_d;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      ref_row_q <= {ROW_W{1'b0}};
    end else begin
      ref_row_q <= ref_row_d;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      bank_count_q <= {`LRS_BANK_W{1'b0}};
    end else begin
      bank_count_q <= bank_count_d;
    end
  end

  // row counter names the next row to refresh
  always @(posedge clock) begin
    if (srst) begin
      row_count_q <= {ROW_W{1'b0}};
    end else begin
      row_count_q <= row_count_d;
    end
  end

  // busy flags pass a flop so every output is registered
  always @(posedge clock) begin
    if (srst) begin
      bank_busy_q <= {`LRS_NBANKS{1'b0}};
    end else begin
      bank_busy_q <= bank_busy_d;
    end
  end
endmodule // lrs_refresh_sched

// ---- testbench/lrs_ctrl_model.sv ----
// memory controller model issuing refresh commands on cs and ca
`timescale 1ns/100ps
module lrs_ctrl_model #(parameter GAP = 5) (
  input  wire logic       clock,
  input  wire logic       srst,
  output logic            cs,
  output logic            sr_exit,
  output logic [5:0]      ca);
  logic [7:0] done = 8'h00;
  initial begin
    cs = 0;
    sr_exit = 0;
    ca = 6'h00;
  end
  always @(posedge srst) done = 8'h00;
  // released bus toggles so stale values never look valid
  task tick; @(negedge clock); cs = 0; ca = ~ca; sr_exit = 0; endtask
  task rest; repeat (GAP) tick; endtask
  task pb(input [2:0] r, output [2:0] b);
    b = r;
    while (done[b]) b = b + 3'h1;
    done[b] = 1;
    if (&done) done = 8'h00;
    @(negedge clock); cs = 1; ca = 6'h08;
    @(negedge clock); cs = 0; ca = {3'h0, b};
    tick;
  endtask
  task ab; done = 8'h00; @(negedge clock); cs = 1; ca = 6'h28; tick; endtask
  task srx; done = 8'h00; @(negedge clock); sr_exit = 1; tick; endtask
endmodule // lrs_ctrl_model

// ---- testbench/lrs_sva.sv ----
// assertions for the refresh scheduler, bound to its top module
`timescale 1ns/100ps
module lrs_sva #(
  parameter ROW_W  = 16,
  parameter CNT_W  = 8,
  parameter TRFCAB = 28,
  parameter TRFCPB = 14
) (
  input wire logic             clock,
  input wire logic             srst,
  input wire logic             cs,
  input wire logic             sr_exit,
  input wire logic             ref_ab_q,
  input wire logic             ref_pb_q,
  input wire logic [5:0]       ca,
  input wire logic [2:0]       ref_bank_q,
  input wire logic [2:0]       bank_count_q,
  input wire logic [ROW_W-1:0] ref_row_q,
  input wire logic [ROW_W-1:0] row_count_q,
  input wire logic [7:0]       bank_busy_q
);
  logic p2_q;
  int   busy_run_q = 0;
  // cycles bank 0 has stayed busy without a break
  always @(posedge clock) busy_run_q <= (srst || !bank_busy_q[0]) ? 0 : busy_run_q + 1;
  wire ab = cs && ca == 6'h28 && !p2_q && !sr_exit;
  // second edge of a per-bank command ignores cs
  always @(posedge clock) p2_q <= !srst && cs && ca == 6'h08 && !p2_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_pb; cs && ca == 6'h08 && !p2_q && !sr_exit ##1 !sr_exit; endsequence
  a_ab_take: assert property (ab |=> ref_ab_q && bank_count_q == 0 && bank_busy_q == 8'hff)
    else $error("all-bank refresh not taken");
  a_pb_take: assert property (s_pb |=> ref_pb_q && ref_bank_q == $past(ca[2:0]))
    else $error("per-bank refresh not taken");
  a_cnt_step: assert property (s_pb |=> bank_count_q == $past(bank_count_q) + 3'h1)
    else $error("bank count did not step");
  a_row_wrap: assert property (ref_pb_q && $past(bank_count_q) == 3'h7 |-> row_count_q == $past(row_count_q) + 1)
    else $error("row not advanced on wrap");
  a_ab_row: assert property (ref_ab_q |-> ref_row_q == $past(row_count_q) && row_count_q == $past(row_count_q) + 1)
    else $error("all-bank row use wrong");
  a_pb_row: assert property (ref_pb_q |-> bank_busy_q[ref_bank_q] && ref_row_q == $past(row_count_q))
    else $error("per-bank row or busy wrong");
  a_srx_zero: assert property (sr_exit |=> bank_count_q == 0)
    else $error("self refresh exit kept count");
  a_rst_zero: assert property (disable iff (1'b0) srst |=> bank_count_q == 0 && row_count_q == 0 && !ref_pb_q)
    else $error("reset did not clear counts");
  a_busy_len: assert property (busy_run_q <= TRFCAB + 1)
    else $error("bank busy held too long");
endmodule // lrs_sva
bind lrs_refresh_sched lrs_sva #(.ROW_W(ROW_W), .CNT_W(CNT_W), .TRFCAB(TRFCAB), .TRFCPB(TRFCPB)) u_sva (.*);

// ---- testbench/tb_top.sv ----
// testbench for the refresh scheduler
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clock = 0, srst = 1, cs, sr_exit, ab, pb;
  logic [5:0] ca;
  logic [2:0] rb, cnt, b, ec;
  logic [15:0] rr, row, er;
  logic [7:0] busy;
  logic [31:0] r = 32'h32f78254;
  int n_fail = 0, cmp_count = 0;
  initial forever #5 clock = ~clock;
  lrs_refresh_sched #(.TRFCAB(3), .TRFCPB(3)) uut (.clock(clock), .srst(srst), .cs(cs), .ca(ca),
    .sr_exit(sr_exit), .ref_ab_q(ab), .ref_pb_q(pb), .ref_bank_q(rb), .ref_row_q(rr),
    .bank_count_q(cnt), .row_count_q(row), .bank_busy_q(busy));
  lrs_ctrl_model #(.GAP(5)) m (.clock(clock), .srst(srst), .cs(cs), .sr_exit(sr_exit), .ca(ca));
  function [31:0] nx(input [31:0] s); nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
  // row moves only when the set of eight closes
  function [15:0] prow(input [2:0] c, input [15:0] w); prow = (c == 3'h7) ? w + 16'h1 : w; endfunction
  task do_pb;
    r = nx(r);
    m.pb(r[2:0], b);
    `CHK({pb, rb, busy[b], rr}, {1'b1, b, 1'b1, er})
    er = prow(ec, er);
    ec = ec + 3'h1;
    `CHK({cnt, row}, {ec, er})
    m.rest;
    `CHK(busy, 8'h00)
  endtask
  task do_ab;
    m.ab;
    `CHK({ab, cnt, busy, rr}, {1'b1, 3'h0, 8'hff, er})
    er = er + 16'h1;
    ec = 3'h0;
    `CHK(row, er)
    m.rest;
    `CHK(busy, 8'h00)
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    ec = 0; er = 0;
    repeat (2) @(negedge clock);
    srst = 0;
    repeat (19) do_pb;
    do_ab;
    for (int i = 0; i < 40; i++) begin
      r = nx(r);
      if (r[7:5] == 0) do_ab;
      else if (r[7:5] == 1) begin m.srx; ec = 0; `CHK(cnt, 3'h0) end
      else do_pb;
    end
    srst = 1;
    @(negedge clock) srst = 0;
    ec = 0; er = 0;
    `CHK({cnt, row}, 19'h0)
    repeat (9) do_pb;
    results;
  end
  initial begin #200000; n_fail++; results; end
endmodule // tb_top
